// [design/sensor_readout_config_regs.v]
// Sensor readout configuration register bank with class-synchronised apply.
`include "sensor_config_regs.vh"

module sensor_readout_config_regs (
    input  wire                       core_clk,
    input  wire                       resetn,
    input  wire                       wr_en,
    input  wire                       rd_en,
    input  wire [`ADDR_W-1:0]         addr,
    input  wire [`DATA_W-1:0]         wdata,
    output reg  [`DATA_W-1:0]         rdata,
    output reg                        rd_valid,
    output reg                        wr_accept,
    output reg                        wr_refused,
    input  wire                       sensor_idle,
    input  wire                       in_overhead,
    input  wire                       overhead_end,
    input  wire                       integration_start,
    input  wire                       frame_request,
    output wire [`DATA_W-1:0]         total_line_count,
    output wire [16*`WINDOW_COUNT-1:0] window_row_origin,
    output wire [16*`WINDOW_COUNT-1:0] window_row_extent,
    output wire [`DATA_W-1:0]         decimation_offset,
    output wire [`DATA_W-1:0]         decimation_step,
    output wire [1:0]                 filter_mode,
    output wire                       binning_enable,
    output wire                       decimation_enable,
    output wire [1:0]                 readout_mirror,
    output wire                       dual_exposure_enable,
    output wire                       external_exposure_enable,
    output wire [23:0]                integration_time,
    output wire [23:0]                second_integration_time,
    output wire [23:0]                knee_point_one,
    output wire [23:0]                knee_point_two,
    output wire [1:0]                 slope_count,
    output wire [`DATA_W-1:0]         frame_count,
    output wire                       upper_bank_disable,
    output wire [4:0]                 lane_mode,
    output wire [`DATA_W-1:0]         quiescent_tuning_a,
    output wire [`DATA_W-1:0]         quiescent_tuning_b,
    output wire [`DATA_W-1:0]         quiescent_tuning_c
);

    // Update class of each address; decides both write window and apply moment.
    function [2:0] reg_class;
        input [`ADDR_W-1:0] a;
        begin
            if (a == `ADDR_RESERVED_ZERO) begin
                reg_class = `CLASS_ANY;
            end else if (a <= `ADDR_DEC_STEP) begin
                reg_class = `CLASS_OVERHEAD;
            end else if (a == `ADDR_MIRROR) begin
                reg_class = `CLASS_IMMEDIATE;
            end else if (a >= `ADDR_INT_TIME_LO && a <= `ADDR_SLOPE_COUNT) begin
                reg_class = `CLASS_EXPOSURE;
            end else if (a == `ADDR_FRAME_COUNT) begin
                reg_class = `CLASS_FRAME;
            end else if (a <= `ADDR_LAST) begin
                reg_class = `CLASS_QUIESCENT;
            end else begin
                reg_class = `CLASS_UNMAPPED;
            end
        end
    endfunction

    // Implemented bits of each address; the rest stay zero so whole-word writes are safe.
    function [`DATA_W-1:0] field_mask;
        input [`ADDR_W-1:0] a;
        begin
            case (a)
                `ADDR_FEATURE_CTRL:  field_mask = `MASK_FEATURE;
                `ADDR_MIRROR:        field_mask = `MASK_TWO_BITS;
                `ADDR_EXPOSURE_CTRL: field_mask = `MASK_TWO_BITS;
                `ADDR_INT_TIME_HI:   field_mask = `MASK_HIGH_BYTE;
                `ADDR_INT2_TIME_HI:  field_mask = `MASK_HIGH_BYTE;
                `ADDR_KNEE1_HI:      field_mask = `MASK_HIGH_BYTE;
                `ADDR_KNEE2_HI:      field_mask = `MASK_HIGH_BYTE;
                `ADDR_SLOPE_COUNT:   field_mask = `MASK_TWO_BITS;
                `ADDR_LANE_CTRL:     field_mask = `MASK_LANE_CTRL;
                default: begin
                    field_mask = (a <= `ADDR_LAST) ? `MASK_FULL : `MASK_NONE;
                end
            endcase
        end
    endfunction

    // Default value of each address after reset.
    function [`DATA_W-1:0] reset_value;
        input [`ADDR_W-1:0] a;
        begin
            case (a)
                `ADDR_TOTAL_LINES:  reset_value = `RST_TOTAL_LINES;
                `ADDR_DEC_STEP:     reset_value = `RST_DEC_STEP;
                `ADDR_FEATURE_CTRL: reset_value = `RST_FEATURE_CTRL;
                `ADDR_INT_TIME_LO:  reset_value = `RST_INT_TIME_LO;
                `ADDR_INT2_TIME_LO: reset_value = `RST_INT_TIME_LO;
                `ADDR_SLOPE_COUNT:  reset_value = `RST_SLOPE_COUNT;
                `ADDR_FRAME_COUNT:  reset_value = `RST_FRAME_COUNT;
                `ADDR_TUNING_A:     reset_value = `RST_TUNING_A;
                `ADDR_TUNING_B:     reset_value = `RST_TUNING_B;
                `ADDR_TUNING_C:     reset_value = `RST_TUNING_C;
                default:            reset_value = `RST_ZERO;
            endcase
        end
    endfunction

    reg  [2:0]                cur_class;
    reg                       write_allowed;
    wire [16*`REG_COUNT-1:0]  stage_bus;
    wire [16*`REG_COUNT-1:0]  apply_bus;
    wire                      write_ok;

    // Write window check. Out-of-window writes are dropped rather than staged, so a
    // misbehaving controller cannot tear a frame that is already being read out.
    always @* begin
        cur_class = reg_class(addr);
        case (cur_class)
            `CLASS_ANY:       write_allowed = 1'b1;
            `CLASS_OVERHEAD:  write_allowed = sensor_idle | in_overhead;
            `CLASS_EXPOSURE:  write_allowed = sensor_idle | in_overhead;
            `CLASS_IMMEDIATE: write_allowed = sensor_idle | in_overhead;
            `CLASS_FRAME:     write_allowed = sensor_idle;
            `CLASS_QUIESCENT: write_allowed = sensor_idle;
            default:          write_allowed = 1'b0;
        endcase
    end

    assign write_ok = wr_en & write_allowed;

    // One staged word and one applied word per address.
    genvar a;
    generate
        for (a = 0; a < `REG_COUNT; a = a + 1) begin : gen_reg
            localparam [`ADDR_W-1:0] ADDR = a;
            localparam [2:0]         CLS  = reg_class(ADDR);
            reg  [`DATA_W-1:0] stage_reg;
            reg  [`DATA_W-1:0] apply_reg;
            reg  [`DATA_W-1:0] stage_next;
            reg  [`DATA_W-1:0] apply_next;
            reg                apply_now;

            // Stage the write; reserved bits are forced to zero.
            always @* begin
                stage_next = stage_reg;
                if (write_ok && addr == ADDR) begin
                    stage_next = wdata & field_mask(ADDR);
                end
            end

            // Pick the moment the staged value reaches the readout logic. The staged
            // next value is used so a write in the same cycle as the event is kept.
            always @* begin
                case (CLS)
                    `CLASS_OVERHEAD: apply_now = overhead_end;
                    `CLASS_EXPOSURE: apply_now = integration_start;
                    `CLASS_FRAME:    apply_now = frame_request;
                    default:         apply_now = 1'b1;
                endcase
                apply_next = apply_now ? stage_next : apply_reg;
            end

            // Both copies load the default on reset.
            always @(posedge core_clk) begin
                if (!resetn) begin
                    stage_reg <= reset_value(ADDR);
                    apply_reg <= reset_value(ADDR);
                end else begin
                    stage_reg <= stage_next;
                    apply_reg <= apply_next;
                end
            end

            assign stage_bus[16*a +: 16] = stage_reg;
            assign apply_bus[16*a +: 16] = apply_reg;
        end
    endgenerate

    // Readback shows the programmed value, not the applied one; unmapped reads return zero.
    always @(posedge core_clk) begin
        if (!resetn) begin
            rdata      <= `RST_ZERO;
            rd_valid   <= 1'b0;
            wr_accept  <= 1'b0;
            wr_refused <= 1'b0;
        end else begin
            rd_valid   <= rd_en;
            wr_accept  <= write_ok;
            wr_refused <= wr_en & ~write_allowed;
            if (rd_en) begin
                if (addr <= `ADDR_LAST) begin
                    rdata <= stage_bus[16*addr +: 16];
                end else begin
                    rdata <= `RST_ZERO;
                end
            end
        end
    end

    // Row windows: one origin and one extent per window.
    genvar w;
    generate
        for (w = 0; w < `WINDOW_COUNT; w = w + 1) begin : gen_win
            assign window_row_origin[16*w +: 16] =
                apply_bus[16*(`ADDR_ORIGIN_FIRST + w) +: 16];
            assign window_row_extent[16*w +: 16] =
                apply_bus[16*(`ADDR_EXTENT_FIRST + w) +: 16];
        end
    endgenerate

    // Field extraction from the applied copies.
    assign total_line_count  = apply_bus[16*`ADDR_TOTAL_LINES +: 16];
    assign decimation_offset = apply_bus[16*`ADDR_DEC_OFFSET +: 16];
    assign decimation_step   = apply_bus[16*`ADDR_DEC_STEP +: 16];
    assign filter_mode       = {apply_bus[16*`ADDR_FEATURE_CTRL + `BIT_FILTER_HI],
                                apply_bus[16*`ADDR_FEATURE_CTRL + `BIT_FILTER_LO]};
    assign binning_enable    = apply_bus[16*`ADDR_FEATURE_CTRL + `BIT_BINNING];
    assign decimation_enable = apply_bus[16*`ADDR_FEATURE_CTRL + `BIT_DECIMATION];
    assign readout_mirror    = apply_bus[16*`ADDR_MIRROR +: 2];
    assign dual_exposure_enable     =
        apply_bus[16*`ADDR_EXPOSURE_CTRL + `BIT_DUAL_EXPOSURE];
    assign external_exposure_enable =
        apply_bus[16*`ADDR_EXPOSURE_CTRL + `BIT_EXT_EXPOSURE];
    assign integration_time  = {apply_bus[16*`ADDR_INT_TIME_HI +: 8],
                                apply_bus[16*`ADDR_INT_TIME_LO +: 16]};
    assign second_integration_time = {apply_bus[16*`ADDR_INT2_TIME_HI +: 8],
                                      apply_bus[16*`ADDR_INT2_TIME_LO +: 16]};
    assign knee_point_one    = {apply_bus[16*`ADDR_KNEE1_HI +: 8],
                                apply_bus[16*`ADDR_KNEE1_LO +: 16]};
    assign knee_point_two    = {apply_bus[16*`ADDR_KNEE2_HI +: 8],
                                apply_bus[16*`ADDR_KNEE2_LO +: 16]};
    assign slope_count       = apply_bus[16*`ADDR_SLOPE_COUNT +: 2];
    assign frame_count       = apply_bus[16*`ADDR_FRAME_COUNT +: 16];
    assign upper_bank_disable = apply_bus[16*`ADDR_LANE_CTRL + `BIT_UPPER_DISABLE];
    assign lane_mode         = apply_bus[16*`ADDR_LANE_CTRL +: (`LANE_MODE_MSB + 1)];
    assign quiescent_tuning_a = apply_bus[16*`ADDR_TUNING_A +: 16];
    assign quiescent_tuning_b = apply_bus[16*`ADDR_TUNING_B +: 16];
    assign quiescent_tuning_c = apply_bus[16*`ADDR_TUNING_C +: 16];

endmodule // sensor_readout_config_regs

// [design/sensor_config_regs.vh]
// Constants for the sensor readout configuration register bank.
// Behaviour
// - All registers load their defaults on reset.
// - Total line count at 1, default 3072, overhead-synced.
// - Thirty-two row origins at 2..33, zero, overhead-synced.
// - Thirty-two row extents at 34..65, zero, overhead-synced.
// - Decimation offset 66 (0), step 67 (1), overhead-synced.
// - Register 68 filter, binning, decimation bits, default 9.
// - Two-bit mirror field at 69, default 0, immediate.
// - Register 70 dual/external exposure enables, quiescent only.
// - Integration time 24 bits at 71/72, default 1536.
// - Second integration time at 73/74, default 1536.
// - Two knee points at 75..78, zero, integration-synced.
// - Slope count at 79, default 1, integration-synced.
// - Frame count at 80, default 1, frame-request synced.
// - Register 81 upper-bank disable and lane mode.
// - Overhead class written idle/overhead, applied at overhead end.
// - Integration class written idle/overhead, latched at integration.
// - Frame class written idle, latched at frame request.
// - Quiescent and immediate classes apply at once.
`ifndef SENSOR_CONFIG_REGS_VH
`define SENSOR_CONFIG_REGS_VH

`define ADDR_W              7
`define DATA_W              16
`define REG_COUNT           85
`define ADDR_LAST           7'h54
`define WINDOW_COUNT        32

`define ADDR_RESERVED_ZERO  7'h00
`define ADDR_TOTAL_LINES    7'h01
`define ADDR_ORIGIN_FIRST   7'h02
`define ADDR_ORIGIN_LAST    7'h21
`define ADDR_EXTENT_FIRST   7'h22
`define ADDR_EXTENT_LAST    7'h41
`define ADDR_DEC_OFFSET     7'h42
`define ADDR_DEC_STEP       7'h43
`define ADDR_FEATURE_CTRL   7'h44
`define ADDR_MIRROR         7'h45
`define ADDR_EXPOSURE_CTRL  7'h46
`define ADDR_INT_TIME_LO    7'h47
`define ADDR_INT_TIME_HI    7'h48
`define ADDR_INT2_TIME_LO   7'h49
`define ADDR_INT2_TIME_HI   7'h4A
`define ADDR_KNEE1_LO       7'h4B
`define ADDR_KNEE1_HI       7'h4C
`define ADDR_KNEE2_LO       7'h4D
`define ADDR_KNEE2_HI       7'h4E
`define ADDR_SLOPE_COUNT    7'h4F
`define ADDR_FRAME_COUNT    7'h50
`define ADDR_LANE_CTRL      7'h51
`define ADDR_TUNING_A       7'h52
`define ADDR_TUNING_B       7'h53
`define ADDR_TUNING_C       7'h54

`define RST_ZERO            16'h0000
`define RST_TOTAL_LINES     16'h0C00
`define RST_DEC_STEP        16'h0001
`define RST_FEATURE_CTRL    16'h0009
`define RST_INT_TIME_LO     16'h0600
`define RST_SLOPE_COUNT     16'h0001
`define RST_FRAME_COUNT     16'h0001
`define RST_TUNING_A        16'h1632
`define RST_TUNING_B        16'h1705
`define RST_TUNING_C        16'h0082

`define MASK_FULL           16'hFFFF
`define MASK_NONE           16'h0000
`define MASK_HIGH_BYTE      16'h00FF
`define MASK_TWO_BITS       16'h0003
`define MASK_FEATURE        16'h000F
`define MASK_LANE_CTRL      16'h003F

`define BIT_FILTER_HI       3
`define BIT_BINNING         2
`define BIT_DECIMATION      1
`define BIT_FILTER_LO       0
`define BIT_DUAL_EXPOSURE   1
`define BIT_EXT_EXPOSURE    0
`define BIT_UPPER_DISABLE   5
`define LANE_MODE_MSB       4

`define CLASS_ANY           3'h0
`define CLASS_OVERHEAD      3'h1
`define CLASS_FRAME         3'h2
`define CLASS_EXPOSURE      3'h3
`define CLASS_IMMEDIATE     3'h4
`define CLASS_QUIESCENT     3'h5
`define CLASS_UNMAPPED      3'h7

`endif

// [dv/sensor_readout_config_regs_sva.sv]
// Port-level assertions for the sensor readout configuration register bank.
`include "sensor_config_regs.vh"

module sensor_readout_config_regs_sva (
    input logic                core_clk,
    input logic                resetn,
    input logic                wr_en,
    input logic                rd_en,
    input logic [`ADDR_W-1:0]  addr,
    input logic [`DATA_W-1:0]  wdata,
    input logic                rd_valid,
    input logic                wr_accept,
    input logic                wr_refused,
    input logic                sensor_idle,
    input logic                in_overhead,
    input logic                overhead_end,
    input logic                integration_start,
    input logic                frame_request,
    input logic [`DATA_W-1:0]  total_line_count,
    input logic [23:0]         integration_time,
    input logic [`DATA_W-1:0]  frame_count,
    input logic [1:0]          readout_mirror,
    input logic                upper_bank_disable,
    input logic [4:0]          lane_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    // Every check shares the one clock, and reset silences all of them.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Each write gets exactly one verdict, one cycle later.
    chk_write_answer: assert property (wr_en |=> wr_accept != wr_refused)
        else $error("write without a single verdict");
    chk_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    chk_quiet_port: assert property (!wr_en |=> !wr_accept && !wr_refused)
        else $error("verdict without a write");
    chk_unmapped_write: assert property (wr_en && addr > `ADDR_LAST |=> wr_refused)
        else $error("unmapped write accepted");
    // Address 0 is the only place open while the sensor is busy outside overhead.
    chk_busy_refusal: assert property (
        wr_en && addr != `ADDR_RESERVED_ZERO && !sensor_idle && !in_overhead |=> wr_refused)
        else $error("write accepted while sensor busy");
    chk_quiescent_only: assert property (
        wr_en && !sensor_idle && (addr == `ADDR_FEATURE_CTRL || addr == `ADDR_EXPOSURE_CTRL
        || addr >= `ADDR_FRAME_COUNT) |=> wr_refused)
        else $error("quiescent register written while active");
    // Synced copies may move only on their own event.
    chk_overhead_hold: assert property (
        !overhead_end |=> $stable(total_line_count))
        else $error("line count changed without overhead end");
    chk_exposure_hold: assert property (
        !integration_start |=> $stable(integration_time))
        else $error("integration time changed without integration start");
    chk_frame_hold: assert property (!frame_request |=> $stable(frame_count))
        else $error("frame count changed without frame request");
    chk_mirror_apply: assert property (
        wr_en && addr == `ADDR_MIRROR && (sensor_idle || in_overhead)
        |=> readout_mirror == $past(wdata[1:0]))
        else $error("mirror not applied at once");
    chk_lane_guard: assert property (
        wr_en && addr == `ADDR_LANE_CTRL && !sensor_idle
        |=> $stable({upper_bank_disable, lane_mode}))
        else $error("lane control changed by refused write");
endmodule // sensor_readout_config_regs_sva

// [dv/config_ctrl_model.sv]
// Camera controller model that issues single register transfers on request.
module config_ctrl_model (
    input  logic        core_clk,
    input  logic        resetn,
    input  logic        go,
    input  logic        go_wr,
    input  logic [6:0]  go_addr,
    input  logic [15:0] go_data,
    output logic        wr_en,
    output logic        rd_en,
    output logic [6:0]  addr,
    output logic [15:0] wdata,
    input  logic [15:0] rdata,
    input  logic        rd_valid,
    input  logic        wr_accept,
    input  logic        wr_refused,
    output logic        done,
    output logic [15:0] res_data,
    output logic [1:0]  res_code
);
    timeunit 1ns;
    timeprecision 1ps;

    // Known levels at time zero, before the first reset edge.
    initial begin
        {wr_en, rd_en, done, addr, wdata, res_data, res_code} = '0;
    end

    // Only wr_en, rd_en and done have a fixed value to restore after reset.
    // Between transfers the address and data lines toggle so stale values never look valid.
    always @(posedge core_clk) begin
        if (!resetn) begin
            {wr_en, rd_en, done} <= 3'h0;
        end else begin
            wr_en <= go & go_wr;
            rd_en <= go & ~go_wr;
            addr  <= go ? go_addr : ~addr;
            wdata <= go ? go_data : ~wdata;
            if (go) begin
                done <= 1'b0;
            end else if (rd_valid | wr_accept | wr_refused) begin
                done     <= 1'b1;
                res_data <= rdata;
                res_code <= {wr_accept, wr_refused};
            end
        end
    end
endmodule // config_ctrl_model

// [dv/sensor_readout_config_regs_tb.sv]
// Self-checking testbench for the sensor readout configuration register bank.
module sensor_readout_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, resetn = 1'b0, go = 1'b0, go_wr = 1'b0, done;
    logic [6:0]  go_addr = 7'h00;
    logic [15:0] go_data = 16'h0000, res_data;
    logic [1:0]  res_code;
    logic        sensor_idle = 1'b1, in_overhead = 1'b0;
    logic        overhead_end = 1'b0, integration_start = 1'b0, frame_request = 1'b0;
    wire         wr_en, rd_en, rd_valid, wr_accept, wr_refused, binning_enable;
    wire         decimation_enable, dual_exposure_enable, external_exposure_enable;
    wire         upper_bank_disable;
    wire [6:0]   addr;
    wire [4:0]   lane_mode;
    wire [1:0]   filter_mode, readout_mirror, slope_count;
    wire [15:0]  wdata, rdata, total_line_count, decimation_offset, decimation_step, frame_count;
    wire [15:0]  quiescent_tuning_a, quiescent_tuning_b, quiescent_tuning_c;
    wire [511:0] window_row_origin, window_row_extent;
    wire [23:0]  integration_time, second_integration_time, knee_point_one, knee_point_two;
    int          n_errors = 0, check_count = 0;

    always #12.5 core_clk = ~core_clk;
    sensor_readout_config_regs u_dut (.*);
    config_ctrl_model u_ctrl (.*);

    // Writable bits of each word; everything else reads zero.
    function automatic logic [15:0] msk(input logic [6:0] a);
        case (a)
            7'h44: msk = 16'h000F;
            7'h45, 7'h46, 7'h4F: msk = 16'h0003;
            7'h48, 7'h4A, 7'h4C, 7'h4E: msk = 16'h00FF;
            7'h51: msk = 16'h003F;
            default: msk = (a > 7'h54) ? 16'h0000 : 16'hFFFF;
        endcase
    endfunction
    function automatic logic [15:0] defv(input logic [6:0] a);
        case (a)
            7'h01: defv = 16'h0C00;
            7'h43, 7'h4F, 7'h50: defv = 16'h0001;
            7'h44: defv = 16'h0009;
            7'h47, 7'h49: defv = 16'h0600;
            7'h52: defv = 16'h1632;
            7'h53: defv = 16'h1705;
            7'h54: defv = 16'h0082;
            default: defv = 16'h0000;
        endcase
    endfunction
    // Address-dependent pattern, so a decode slip shows as a wrong word.
    function automatic logic [15:0] pat(input logic [6:0] a);
        pat = 16'hC3A5 ^ {a, 2'b00, a};
    endfunction

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d);
        int i;
        @(posedge core_clk);
        go <= 1'b1; go_wr <= w; go_addr <= a; go_data <= d;
        @(posedge core_clk);
        go <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            if (done === 1'b1) break;
        end
        if (done !== 1'b1) check("transfer completion", 24'h1, 24'h0);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] code);
        xfer(1'b1, a, d);
        check("write status", code, res_code);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        xfer(1'b0, a, 16'h0000);
        check("read data", exp, res_data);
    endtask
    // One-cycle event pulses: bit 0 overhead end, bit 1 integration start, bit 2 frame request.
    task automatic pulse(input logic [2:0] m);
        @(posedge core_clk);
        {frame_request, integration_start, overhead_end} <= m;
        @(posedge core_clk);
        {frame_request, integration_start, overhead_end} <= 3'h0;
        #1;
    endtask
    task automatic chk_defaults();
        int a;
        for (a = 0; a <= 85; a++) rd(a[6:0], defv(a[6:0]));
        check("line count", 24'h000C00, total_line_count);
        check("step", 24'h000001, decimation_step);
        check("features", 24'hC, {filter_mode, binning_enable, decimation_enable});
        check("integration", 24'h000600, integration_time);
        check("second integration", 24'h000600, second_integration_time);
        check("slopes", 24'h000001, slope_count);
        check("frames", 24'h000001, frame_count);
        check("mirror", 24'h000000, readout_mirror);
        check("tuning a", 24'h001632, quiescent_tuning_a);
        check("tuning b", 24'h001705, quiescent_tuning_b);
        check("tuning c", 24'h000082, quiescent_tuning_c);
        $display("test defaults done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // The run needs about 1500 cycles; the watchdog allows four times that.
    initial begin
        #(25ns * 6000);
        n_errors++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        int a;
        logic [15:0] pv;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        chk_defaults();
        // Idle writes everywhere; the unmapped word must be refused.
        for (a = 0; a <= 85; a++) wr(a[6:0], pat(a[6:0]), {a < 85, a > 84});
        check("line count staged", 24'h000C00, total_line_count);
        check("integration staged", 24'h000600, integration_time);
        check("frames staged", 24'h000001, frame_count);
        check("mirror", pat(7'h45) & 16'h3, readout_mirror);
        check("lane", pat(7'h51) & 16'h3F, {upper_bank_disable, lane_mode});
        check("tuning b", pat(7'h53), quiescent_tuning_b);
        pv = pat(7'h46);
        check("exposure bits", pv[1:0],
            {dual_exposure_enable, external_exposure_enable});
        pv = pat(7'h44);
        check("features", {pv[3], pv[0], pv[2:1]},
            {filter_mode, binning_enable, decimation_enable});
        for (a = 0; a <= 85; a++) rd(a[6:0], pat(a[6:0]) & msk(a[6:0]));
        pulse(3'b001);
        check("line count", pat(7'h01), total_line_count);
        check("origin first", pat(7'h02), window_row_origin[15:0]);
        check("origin last", pat(7'h21), window_row_origin[511:496]);
        check("extent first", pat(7'h22), window_row_extent[15:0]);
        check("extent last", pat(7'h41), window_row_extent[511:496]);
        check("decimation offset", pat(7'h42), decimation_offset);
        check("decimation step", pat(7'h43), decimation_step);
        check("integration held", 24'h000600, integration_time);
        pulse(3'b010);
        check("integration", {8'(pat(7'h48)), pat(7'h47)}, integration_time);
        check("second", {8'(pat(7'h4A)), pat(7'h49)}, second_integration_time);
        check("knee one", {8'(pat(7'h4C)), pat(7'h4B)}, knee_point_one);
        check("knee two", {8'(pat(7'h4E)), pat(7'h4D)}, knee_point_two);
        check("slopes", pat(7'h4F) & 16'h3, slope_count);
        check("frames held", 24'h000001, frame_count);
        pulse(3'b100);
        check("frames", pat(7'h50), frame_count);
        $display("test idle writes done");
        // Overhead time: only idle-class registers are refused; once busy outside overhead, only address 0 is open.
        @(posedge core_clk);
        sensor_idle <= 1'b0;
        in_overhead <= 1'b1;
        wr(7'h44, 16'h0000, 2'b01);
        wr(7'h46, 16'h0000, 2'b01);
        wr(7'h50, 16'h0000, 2'b01);
        wr(7'h51, 16'h0000, 2'b01);
        wr(7'h47, 16'h1234, 2'b10);
        wr(7'h45, 16'h0002, 2'b10);
        check("mirror at once", 24'h000002, readout_mirror);
        wr(7'h01, 16'h0042, 2'b10);
        @(posedge core_clk);
        in_overhead <= 1'b0;
        wr(7'h02, 16'h0000, 2'b01);
        wr(7'h49, 16'h0000, 2'b01);
        wr(7'h00, 16'h55AA, 2'b10);
        rd(7'h47, 16'h1234);
        rd(7'h44, pat(7'h44) & 16'hF);
        rd(7'h02, pat(7'h02));
        rd(7'h00, 16'h55AA);
        $display("test sensor states done");
        // Back to idle, the feature word takes a write again and shows it at once.
        @(posedge core_clk);
        sensor_idle <= 1'b1;
        wr(7'h44, 16'h0006, 2'b10);
        check("features set", 24'h000003,
            {filter_mode, binning_enable, decimation_enable});
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        chk_defaults();
        test_done();
    end
endmodule // sensor_readout_config_regs_tb

bind sensor_readout_config_regs sensor_readout_config_regs_sva u_chk (.*);
